//--- ddc_sel_pkg.sv
/*
  Constants for the downconverter two decimation and NCO select block:
  register offsets, field positions, reset values, filter chain codes.
  Assumes a byte-wide register port with one-cycle read latency.
*/
package ddc_sel_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h350;
  localparam logic [11:0] INSEL_OFFSET = 12'h351;
  localparam logic [11:0] NCO_OFFSET = 12'h354;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] INSEL_RESET = 8'h00;
  localparam logic [7:0] NCO_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h0F;
  localparam logic [7:0] INSEL_MASK = 8'hF5;
  localparam logic [7:0] NCO_MASK = 8'hFF;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int C2R_BIT = 3;
  localparam int DEC_MSB = 2;
  localparam int ALT_LSB = 4;
  localparam int MODE_LSB = 4;
  localparam int FIELD_W = 4;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam int I_SEL_BIT = 0;
  localparam int Q_SEL_BIT = 2;

  // ------------------------------------------------------------
  // Decimation codes
  // ------------------------------------------------------------
  localparam logic [2:0] DEC_HB12 = 3'h0;
  localparam logic [2:0] DEC_HB123 = 3'h1;
  localparam logic [2:0] DEC_HB1234 = 3'h2;
  localparam logic [2:0] DEC_HB1 = 3'h3;
  localparam logic [2:0] DEC_HB1_TB = 3'h4;
  localparam logic [2:0] DEC_HB12_TB = 3'h5;
  localparam logic [2:0] DEC_HB123_TB = 3'h6;
  localparam logic [2:0] DEC_ALT = 3'h7;
  localparam logic [3:0] ALT_TB_HB1234 = 4'h0;
  localparam logic [3:0] ALT_FB_HB1 = 4'h2;
  localparam logic [3:0] ALT_FB_HB12 = 4'h3;
  localparam logic [3:0] ALT_FB_HB123 = 4'h4;

  // Stage enable vector: {fifth, third, hb4, hb3, hb2, hb1}
  localparam int STAGE_W = 6;
  localparam int RATIO_W = 6;
  localparam logic [5:0] ST_HB1 = 6'h01;
  localparam logic [5:0] ST_HB12 = 6'h03;
  localparam logic [5:0] ST_HB123 = 6'h07;
  localparam logic [5:0] ST_HB1234 = 6'h0F;
  localparam logic [5:0] ST_TB = 6'h10;
  localparam logic [5:0] ST_FB = 6'h20;
  localparam logic [5:0] ST_NONE = 6'h00;

  // Complex decimation ratios (halved when real output is chosen)
  localparam logic [5:0] R_2 = 6'h02;
  localparam logic [5:0] R_4 = 6'h04;
  localparam logic [5:0] R_6 = 6'h06;
  localparam logic [5:0] R_8 = 6'h08;
  localparam logic [5:0] R_10 = 6'h0A;
  localparam logic [5:0] R_12 = 6'h0C;
  localparam logic [5:0] R_16 = 6'h10;
  localparam logic [5:0] R_20 = 6'h14;
  localparam logic [5:0] R_24 = 6'h18;
  localparam logic [5:0] R_40 = 6'h28;
  localparam logic [5:0] R_48 = 6'h30;
  localparam logic [5:0] R_NONE = 6'h00;

  // ------------------------------------------------------------
  // NCO channel select modes
  // ------------------------------------------------------------
  localparam logic [3:0] NM_REG = 4'h0;
  localparam logic [3:0] NM_B0A0 = 4'h1;
  localparam logic [3:0] NM_B1A1 = 4'h2;
  localparam logic [3:0] NM_A1A0 = 4'h3;
  localparam logic [3:0] NM_B1B0 = 4'h4;
  localparam logic [3:0] NM_INTERLV = 4'h5;
  localparam logic [3:0] NM_PAIRED = 4'h6;
  localparam logic [3:0] NM_EDGE_A0 = 4'h8;
  localparam logic [3:0] NM_EDGE_A1 = 4'h9;
  localparam logic [3:0] NM_EDGE_B0 = 4'hA;
  localparam logic [3:0] NM_EDGE_B1 = 4'hB;
  localparam int CHAN_W = 4;
  localparam int PIN_N = 4;

endpackage : ddc_sel_pkg

//--- pin_sync.sv
/*
  Two-stage synchroniser bank with rising-edge detect on the settled
  stage. Assumes asynchronous pin levels and one system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge clk_sys_i)
      begin
        if (sys_rst_i)
        begin
          meta_reg[g] <= 1'h0;
          sync_reg[g] <= 1'h0;
          prev_reg[g] <= 1'h0;
        end
        else
        begin
          meta_reg[g] <= pin_i[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
        end
      end
      assign rise_o[g] = sync_reg[g] & ~prev_reg[g];
    end
  endgenerate

  assign level_o = sync_reg;

endmodule : pin_sync
`default_nettype wire

//--- ddc_decimation_nco_select.sv
/*
  Decimation chain select, I/Q input select and NCO channel select for
  downconverter two. Holds the three control registers on a byte port.
  Assumes control pins are asynchronous and held stable for at least
  three clock cycles per level.
*/
// Added by the designer: the plain strobed port.
// Function
// R1: Code 000 uses stages one and two, ratio 4, or 2 when real.
// R2: Code 001 uses stages one to three, ratio 8, or 4 when real.
// R3: Code 010 uses all four half-band stages, ratio 16, or 8 real.
// R4: Code 011 uses stage one only, ratio 2, or 1 when real.
// R5: Code 100 uses stage one plus third-band, ratio 6, or 3 real.
// R6: Code 101 uses stages one, two plus third-band, ratio 12 or 6.
// R7: Code 110 uses stages one to three plus third-band, 24 or 12.
// R8: Code 111 takes the chain from the alternate field bits 7:4.
// R9: Alternate field is ignored unless primary code is all ones.
// R10: Alternate 0 uses third-band plus four half-bands, 48 or 24.
// R11: Alternate 2 uses fifth-band plus stage one, 10 or 5.
// R12: Alternate 3 uses fifth-band plus stages one, two, 20 or 10.
// R13: Alternate 4 uses fifth-band plus stages one to three, 40 or 20.
// R14: I and Q select bits choose converter A when clear, B when set.
// R15: Edge-driven counter wraps to zero on reaching the select field.
// R16: Modes 1 and 2 index from pins B0,A0 or B1,A1.
// R17: Modes 3 and 4 index from pins A1,A0 or B1,B0.
// R18: Mode 5 is B1,A1,B0,A0; mode 6 is B1,B0,A1,A0.
// R19: Modes 8, 9, 10 count rising edges of A0, A1, B0.
// R20: Mode 11 counts rising edges of B1.
// R21: Real mode keeps only I output valid, using quarter-rate mixing.
// R22: Mode 0 takes the index straight from the select field.
// R23: Reserved bits ignore writes and read as zero.
`timescale 1ns/1ns
`default_nettype none
module ddc_decimation_nco_select #(
  parameter int CH_W = ddc_sel_pkg::CHAN_W
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ctrl_pin_a_bit0_i,
  input wire logic ctrl_pin_a_bit1_i,
  input wire logic ctrl_pin_b_bit0_i,
  input wire logic ctrl_pin_b_bit1_i,
  output logic [5:0] stage_enable_o,
  output logic [5:0] decim_ratio_o,
  output logic real_output_o,
  output logic q_output_valid_o,
  output logic quarter_mix_enable_o,
  output logic i_from_b_o,
  output logic q_from_b_o,
  output logic [CH_W-1:0] nco_channel_o
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] insel_reg;
  logic [7:0] nco_reg;

  // R23: reserved masked
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg <= ddc_sel_pkg::CTRL_RESET;
      insel_reg <= ddc_sel_pkg::INSEL_RESET;
      nco_reg <= ddc_sel_pkg::NCO_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == ddc_sel_pkg::CTRL_OFFSET)
        ctrl_reg <= reg_wdata_i & ddc_sel_pkg::CTRL_MASK;
      if (reg_addr_i == ddc_sel_pkg::INSEL_OFFSET)
        insel_reg <= reg_wdata_i & ddc_sel_pkg::INSEL_MASK;
      if (reg_addr_i == ddc_sel_pkg::NCO_OFFSET)
        nco_reg <= reg_wdata_i & ddc_sel_pkg::NCO_MASK;
    end
  end

  // Unmapped addresses read zero; data only in the cycle after strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= ddc_sel_pkg::RDATA_IDLE;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ddc_sel_pkg::CTRL_OFFSET: reg_rdata_o <= ctrl_reg;
        ddc_sel_pkg::INSEL_OFFSET: reg_rdata_o <= insel_reg;
        ddc_sel_pkg::NCO_OFFSET: reg_rdata_o <= nco_reg;
        default: reg_rdata_o <= ddc_sel_pkg::RDATA_IDLE;
      endcase
    end
    else
      reg_rdata_o <= ddc_sel_pkg::RDATA_IDLE;
  end

  // ------------------------------------------------------------
  // Decimation chain
  // ------------------------------------------------------------
  logic [2:0] dec_code;
  logic [3:0] alt_code;
  logic c2r;
  logic [5:0] stage_next;
  logic [5:0] cplx_ratio;

  assign dec_code = ctrl_reg[ddc_sel_pkg::DEC_MSB:0];
  assign alt_code = insel_reg[ddc_sel_pkg::ALT_LSB +: ddc_sel_pkg::FIELD_W];
  assign c2r = ctrl_reg[ddc_sel_pkg::C2R_BIT];

  always_comb
  begin
    stage_next = ddc_sel_pkg::ST_NONE;
    cplx_ratio = ddc_sel_pkg::R_NONE;
    unique case (dec_code)
      // R1: two half-bands
      ddc_sel_pkg::DEC_HB12:
      begin
        stage_next = ddc_sel_pkg::ST_HB12;
        cplx_ratio = ddc_sel_pkg::R_4;
      end
      // R2: three half-bands
      ddc_sel_pkg::DEC_HB123:
      begin
        stage_next = ddc_sel_pkg::ST_HB123;
        cplx_ratio = ddc_sel_pkg::R_8;
      end
      // R3: four half-bands
      ddc_sel_pkg::DEC_HB1234:
      begin
        stage_next = ddc_sel_pkg::ST_HB1234;
        cplx_ratio = ddc_sel_pkg::R_16;
      end
      // R4: first half-band
      ddc_sel_pkg::DEC_HB1:
      begin
        stage_next = ddc_sel_pkg::ST_HB1;
        cplx_ratio = ddc_sel_pkg::R_2;
      end
      // R5: half-band plus third
      ddc_sel_pkg::DEC_HB1_TB:
      begin
        stage_next = ddc_sel_pkg::ST_HB1 | ddc_sel_pkg::ST_TB;
        cplx_ratio = ddc_sel_pkg::R_6;
      end
      // R6: two plus third
      ddc_sel_pkg::DEC_HB12_TB:
      begin
        stage_next = ddc_sel_pkg::ST_HB12 | ddc_sel_pkg::ST_TB;
        cplx_ratio = ddc_sel_pkg::R_12;
      end
      // R7: three plus third
      ddc_sel_pkg::DEC_HB123_TB:
      begin
        stage_next = ddc_sel_pkg::ST_HB123 | ddc_sel_pkg::ST_TB;
        cplx_ratio = ddc_sel_pkg::R_24;
      end
      // R8: alternate field
      // R9: only reached here
      ddc_sel_pkg::DEC_ALT:
      begin
        unique case (alt_code)
          // R10: third plus four
          ddc_sel_pkg::ALT_TB_HB1234:
          begin
            stage_next = ddc_sel_pkg::ST_HB1234 | ddc_sel_pkg::ST_TB;
            cplx_ratio = ddc_sel_pkg::R_48;
          end
          // R11: fifth plus one
          ddc_sel_pkg::ALT_FB_HB1:
          begin
            stage_next = ddc_sel_pkg::ST_HB1 | ddc_sel_pkg::ST_FB;
            cplx_ratio = ddc_sel_pkg::R_10;
          end
          // R12: fifth plus two
          ddc_sel_pkg::ALT_FB_HB12:
          begin
            stage_next = ddc_sel_pkg::ST_HB12 | ddc_sel_pkg::ST_FB;
            cplx_ratio = ddc_sel_pkg::R_20;
          end
          // R13: fifth plus three
          ddc_sel_pkg::ALT_FB_HB123:
          begin
            stage_next = ddc_sel_pkg::ST_HB123 | ddc_sel_pkg::ST_FB;
            cplx_ratio = ddc_sel_pkg::R_40;
          end
          // Undefined alternates bypass every stage
          default:
          begin
            stage_next = ddc_sel_pkg::ST_NONE;
            cplx_ratio = ddc_sel_pkg::R_NONE;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      stage_enable_o <= ddc_sel_pkg::ST_HB12;
      decim_ratio_o <= ddc_sel_pkg::R_4;
    end
    else
    begin
      stage_enable_o <= stage_next;
      // R21: real halves ratio
      decim_ratio_o <= c2r ? (cplx_ratio >> 1) : cplx_ratio;
    end
  end

  // ------------------------------------------------------------
  // Output form and input routing
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      real_output_o <= 1'h0;
      q_output_valid_o <= 1'h1;
      quarter_mix_enable_o <= 1'h0;
      i_from_b_o <= 1'h0;
      q_from_b_o <= 1'h0;
    end
    else
    begin
      // R21: I only when real
      real_output_o <= c2r;
      q_output_valid_o <= ~c2r;
      quarter_mix_enable_o <= c2r;
      // R14: channel A or B
      i_from_b_o <= insel_reg[ddc_sel_pkg::I_SEL_BIT];
      q_from_b_o <= insel_reg[ddc_sel_pkg::Q_SEL_BIT];
    end
  end

  // ------------------------------------------------------------
  // NCO channel select
  // ------------------------------------------------------------
  logic [3:0] pin_level;
  logic [3:0] pin_rise;
  logic [3:0] nco_mode;
  logic [CH_W-1:0] sw_chan;
  logic [CH_W-1:0] count_reg;
  logic [CH_W-1:0] chan_next;
  logic step;
  logic a0;
  logic a1;
  logic b0;
  logic b1;

  // Pins pass two flops before use
  pin_sync #(
    .WIDTH(ddc_sel_pkg::PIN_N)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({ctrl_pin_b_bit1_i, ctrl_pin_b_bit0_i,
            ctrl_pin_a_bit1_i, ctrl_pin_a_bit0_i}),
    .level_o(pin_level),
    .rise_o(pin_rise)
  );

  assign a0 = pin_level[0];
  assign a1 = pin_level[1];
  assign b0 = pin_level[2];
  assign b1 = pin_level[3];
  assign nco_mode = nco_reg[ddc_sel_pkg::MODE_LSB +: ddc_sel_pkg::FIELD_W];
  assign sw_chan = nco_reg[CH_W-1:0];

  always_comb
  begin
    unique case (nco_mode)
      // R19: edge sources
      ddc_sel_pkg::NM_EDGE_A0: step = pin_rise[0];
      ddc_sel_pkg::NM_EDGE_A1: step = pin_rise[1];
      ddc_sel_pkg::NM_EDGE_B0: step = pin_rise[2];
      // R20: pin B1 edges
      ddc_sel_pkg::NM_EDGE_B1: step = pin_rise[3];
      default: step = 1'h0;
    endcase
  end

  // Counter holds outside edge modes so a mode switch resumes cleanly
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      count_reg <= '0;
    else if (step)
    begin
      // R15: wrap at limit
      if (count_reg >= sw_chan)
        count_reg <= '0;
      else
        count_reg <= count_reg + 1'h1;
    end
  end

  always_comb
  begin
    unique case (nco_mode)
      // R22: software index
      ddc_sel_pkg::NM_REG: chan_next = sw_chan;
      // R16: two-pin pairs
      ddc_sel_pkg::NM_B0A0: chan_next = {2'h0, b0, a0};
      ddc_sel_pkg::NM_B1A1: chan_next = {2'h0, b1, a1};
      // R17: same-port pairs
      ddc_sel_pkg::NM_A1A0: chan_next = {2'h0, a1, a0};
      ddc_sel_pkg::NM_B1B0: chan_next = {2'h0, b1, b0};
      // R18: four-pin orders
      ddc_sel_pkg::NM_INTERLV: chan_next = {b1, a1, b0, a0};
      ddc_sel_pkg::NM_PAIRED: chan_next = {b1, b0, a1, a0};
      ddc_sel_pkg::NM_EDGE_A0,
      ddc_sel_pkg::NM_EDGE_A1,
      ddc_sel_pkg::NM_EDGE_B0,
      ddc_sel_pkg::NM_EDGE_B1: chan_next = count_reg;
      // Undefined modes fall back to software index
      default: chan_next = sw_chan;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      nco_channel_o <= '0;
    else
      nco_channel_o <= chan_next;
  end

endmodule : ddc_decimation_nco_select
`default_nettype wire

//--- ddc_sel_assertions.sv
/*
  Port checks for the decimation and NCO select block.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ddc_sel_assertions #(
  parameter int CH_W = 4
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [5:0] stage_enable_o,
  input wire logic [5:0] decim_ratio_o,
  input wire logic real_output_o,
  input wire logic q_output_valid_o,
  input wire logic quarter_mix_enable_o,
  input wire logic i_from_b_o,
  input wire logic q_from_b_o,
  input wire logic [CH_W-1:0] nco_channel_o
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_unmapped_read;
    reg_rd_i && !(reg_addr_i inside {12'h350, 12'h351, 12'h354})
      |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_reserved_read;
    reg_rd_i && reg_addr_i == 12'h351
      |=> (reg_rdata_o & 8'h0A) == 8'h00;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved bits read nonzero");

  property p_real_follows;
    reg_wr_i && reg_addr_i == 12'h350
      ##1 !(reg_wr_i && reg_addr_i == 12'h350)
      |=> real_output_o == $past(reg_wdata_i[3], 2)
        && quarter_mix_enable_o == real_output_o
        && q_output_valid_o != real_output_o;
  endproperty
  a_real_follows: assert property (p_real_follows)
    else $error("real output flags wrong");

  property p_code3_hb1;
    reg_wr_i && reg_addr_i == 12'h350 && reg_wdata_i[3:0] == 4'h3
      ##1 !(reg_wr_i && reg_addr_i == 12'h350)
      |=> stage_enable_o == 6'h01 && decim_ratio_o == 6'h02;
  endproperty
  a_code3_hb1: assert property (p_code3_hb1)
    else $error("single half-band chain wrong");

  property p_third_fifth;
    !(stage_enable_o[5] && stage_enable_o[4]);
  endproperty
  a_third_fifth: assert property (p_third_fifth)
    else $error("third and fifth band both on");

  property p_hb1_in_chain;
    stage_enable_o != 6'h00
      |-> stage_enable_o[0] && decim_ratio_o != 6'h00;
  endproperty
  a_hb1_in_chain: assert property (p_hb1_in_chain)
    else $error("chain without first half-band");

  property p_i_select;
    reg_wr_i && reg_addr_i == 12'h351
      ##1 !(reg_wr_i && reg_addr_i == 12'h351)
      |=> i_from_b_o == $past(reg_wdata_i[0], 2);
  endproperty
  a_i_select: assert property (p_i_select)
    else $error("I converter select wrong");

  property p_q_select;
    reg_wr_i && reg_addr_i == 12'h351
      ##1 !(reg_wr_i && reg_addr_i == 12'h351)
      |=> q_from_b_o == $past(reg_wdata_i[2], 2);
  endproperty
  a_q_select: assert property (p_q_select)
    else $error("Q converter select wrong");

  property p_nco_reg_mode;
    reg_wr_i && reg_addr_i == 12'h354 && reg_wdata_i[7:4] == 4'h0
      ##1 !(reg_wr_i && reg_addr_i == 12'h354)
      |=> nco_channel_o == CH_W'($past(reg_wdata_i[3:0], 2));
  endproperty
  a_nco_reg_mode: assert property (p_nco_reg_mode)
    else $error("software channel index wrong");
endmodule : ddc_sel_assertions

bind ddc_decimation_nco_select ddc_sel_assertions #(.CH_W(CH_W)) u_chk (
  .clk_sys_i,
  .sys_rst_i,
  .reg_addr_i,
  .reg_wdata_i,
  .reg_wr_i,
  .reg_rd_i,
  .reg_rdata_o,
  .stage_enable_o,
  .decim_ratio_o,
  .real_output_o,
  .q_output_valid_o,
  .quarter_mix_enable_o,
  .i_from_b_o,
  .q_from_b_o,
  .nco_channel_o
);
`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the decimation and NCO select block.
  Assumes the package, design and checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys_i;
  logic sys_rst_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [11:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic [5:0] stage_enable_o;
  logic [5:0] decim_ratio_o;
  logic real_output_o;
  logic q_output_valid_o;
  logic quarter_mix_enable_o;
  logic i_from_b_o;
  logic q_from_b_o;
  logic [3:0] nco_channel_o;
  // Pins as {b1, b0, a1, a0}
  logic [3:0] p;
  int mismatches;
  int samples_checked;
  logic [11:0] ad_t[4] = '{12'h350, 12'h351, 12'h354, 12'h352};
  logic [7:0] mk_t[4] = '{8'h0F, 8'hF5, 8'hFF, 8'h00};
  logic [5:0] st_t[11] = '{6'h03, 6'h07, 6'h0F, 6'h01, 6'h11, 6'h13,
    6'h17, 6'h1F, 6'h21, 6'h23, 6'h27};
  logic [5:0] rt_t[11] = '{6'h04, 6'h08, 6'h10, 6'h02, 6'h06, 6'h0C,
    6'h18, 6'h30, 6'h0A, 6'h14, 6'h28};
  logic [7:0] in_t[4] = '{8'h00, 8'h20, 8'h30, 8'h40};
  logic [3:0] nco_t[7] = '{4'hC, 4'h1, 4'h3, 4'h3, 4'h2, 4'hD, 4'hB};

  ddc_decimation_nco_select dut (
    .clk_sys_i,
    .sys_rst_i,
    .reg_addr_i,
    .reg_wdata_i,
    .reg_wr_i,
    .reg_rd_i,
    .reg_rdata_o,
    .ctrl_pin_a_bit0_i(p[0]),
    .ctrl_pin_a_bit1_i(p[1]),
    .ctrl_pin_b_bit0_i(p[2]),
    .ctrl_pin_b_bit1_i(p[3]),
    .stage_enable_o,
    .decim_ratio_o,
    .real_output_o,
    .q_output_valid_o,
    .quarter_mix_enable_o,
    .i_from_b_o,
    .q_from_b_o,
    .nco_channel_o
  );

  // --------
  // Tasks
  // --------
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h0;
    @(negedge clk_sys_i);
    chk("rdata", e, reg_rdata_o);
  endtask : rdc

  // Settle away from the edge before looking at outputs
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : wt

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // --------
  // Sequence
  // --------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Run needs under 1000 cycles; generous margin
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    sys_rst_i = 1'h1;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    reg_addr_i = 12'h000;
    reg_wdata_i = 8'h00;
    p = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    wt(1);
    chk("stage", 8'h03, 8'(stage_enable_o));
    chk("ratio", 8'h04, 8'(decim_ratio_o));
    for (int k = 0; k < 4; k++)
    begin
      rdc(ad_t[k], 8'h00);
      wr(ad_t[k], 8'hFF);
      rdc(ad_t[k], mk_t[k]);
    end
    for (int c = 0; c < 11; c++)
    begin
      for (int r = 0; r < 2; r++)
      begin
        wr(12'h351, (c < 7) ? 8'hF0 : in_t[c - 7]);
        wr(12'h350, {4'h0, r[0], (c < 7) ? c[2:0] : 3'h7});
        wt(2);
        chk("stage", 8'(st_t[c]), 8'(stage_enable_o));
        chk("ratio", 8'(rt_t[c] >> r), 8'(decim_ratio_o));
        chk("real", 8'(r), 8'(real_output_o));
        chk("qvalid", 8'(1 - r), 8'(q_output_valid_o));
        chk("mix", 8'(r), 8'(quarter_mix_enable_o));
      end
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(12'h351, k ? 8'h04 : 8'h01);
      wt(2);
      chk("isel", 8'(1 - k), 8'(i_from_b_o));
      chk("qsel", 8'(k), 8'(q_from_b_o));
    end
    @(posedge clk_sys_i);
    p <= 4'hB;
    for (int m = 0; m < 7; m++)
    begin
      wr(12'h354, {m[3:0], 4'hC});
      wt(5);
      chk("nco", 8'(nco_t[m]), 8'(nco_channel_o));
    end
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_sys_i);
      p <= 4'h0;
      wr(12'h354, {2'h2, m[1:0], 4'h2});
      wt(5);
      for (int n = 0; n < 3; n++)
      begin
        @(posedge clk_sys_i);
        p[m] <= 1'h1;
        wt(5);
        @(posedge clk_sys_i);
        p[m] <= 1'h0;
        wt(4);
        chk("count", 8'((n + 1) % 3), 8'(nco_channel_o));
      end
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
